//--- hw/timer_pair_pkg.sv
package timer_pair_pkg;
    // register byte offsets
    localparam logic [7:0] LOW_CTRL_OFF = 8'h00;
    localparam logic [7:0] HIGH_CTRL_OFF = 8'h04;
    localparam logic [7:0] LOW_PERIOD_OFF = 8'h08;
    localparam logic [7:0] HIGH_PERIOD_OFF = 8'h0c;
    localparam logic [7:0] LOW_COUNT_OFF = 8'h10;
    localparam logic [7:0] HIGH_COUNT_OFF = 8'h14;
    localparam logic [7:0] IRQ_FLAG_OFF = 8'h18;
    localparam logic [7:0] IRQ_CFG_OFF = 8'h1c;
    localparam logic [7:0] MISC_OFF = 8'h20;
    // control field positions
    localparam int RUN_BIT = 15;
    localparam int IDLE_STOP_BIT = 13;
    localparam int GATE_BIT = 6;
    localparam int PRESCALE_LSB = 4;
    localparam int WIDE_BIT = 3;
    localparam int CLK_SRC_BIT = 1;
    // writable bits, the rest read zero
    localparam logic [15:0] LOW_CTRL_MASK = 16'ha07a;
    localparam logic [15:0] HIGH_CTRL_MASK = 16'ha072;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    // instruction clock is the core clock divided by two
    localparam logic [0:0] INSN_DIV_LAST = 1'h1;
    // prescale terminal counts
    localparam logic [7:0] PS_DIV1 = 8'h00;
    localparam logic [7:0] PS_DIV8 = 8'h07;
    localparam logic [7:0] PS_DIV64 = 8'h3f;
    localparam logic [7:0] PS_DIV256 = 8'hff;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

//--- hw/tick_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module tick_prescaler
    import timer_pair_pkg::*;
(
    input wire logic sys_clk_i, // clock
    input wire logic rst_n_i, // reset
    input wire logic clear_i, // restart
    input wire logic tick_i, // tick in
    input wire logic [1:0] sel_i, // ratio
    output logic tick_o // tick out
);
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } ps_state_t;
    ps_state_t s_q, s_d;
    logic [7:0] last;

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        case (sel_i)
            2'h0: last = PS_DIV1;
            2'h1: last = PS_DIV8;
            2'h2: last = PS_DIV64;
            default: last = PS_DIV256;
        endcase
        if (clear_i) begin
            s_d.cnt = 8'h00;
        end else if (tick_i) begin
            if (s_q.cnt >= last) begin
                s_d.cnt = 8'h00;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_o = s_q.tick;
endmodule
`default_nettype wire

//--- hw/timer_pair.sv
// Behaviour
// - low timer prescales pin, then synchronises
// - high timer synchronises pin before prescaler
// - internal source is core clock halved
// - external source counts pin; gate ignored
// - prescale ratios 1, 8, 64, 256
// - gate works only with internal source
// - wide bit joins timers into 32
// - high count holds upper word
// - wide mode uses low control, plus high idle stop
// - wide mode interrupts via high flag
// - high period is upper half
// - only this fixed pair concatenates
// - run bit starts and stops counting
// - idle stop halts timer in idle
// - source bit picks pin or internal
// - high timer issues conversion trigger
// - first pair issues dma requests
// - unused control bits read zero
// - 32-bit count readable from pair
`timescale 1ns/100ps
`default_nettype none
module timer_pair
    import timer_pair_pkg::*;
#(
    parameter bit FIRST_PAIR = 1'b1 // first pair raises dma requests
) (
    input wire logic sys_clk_i, // clock
    input wire logic rst_n_i, // reset
    input wire logic idle_mode_i, // idle
    input wire logic low_ext_count_input_i, // low pin
    input wire logic high_ext_count_input_i, // high pin
    input wire logic [7:0] s_axi_awaddr, // aw addr
    input wire logic s_axi_awvalid, // aw valid
    output logic s_axi_awready, // aw ready
    input wire logic [31:0] s_axi_wdata, // w data
    input wire logic [3:0] s_axi_wstrb, // w strobes
    input wire logic s_axi_wvalid, // w valid
    output logic s_axi_wready, // w ready
    output logic [1:0] s_axi_bresp, // b resp
    output logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic [7:0] s_axi_araddr, // ar addr
    input wire logic s_axi_arvalid, // ar valid
    output logic s_axi_arready, // ar ready
    output logic [31:0] s_axi_rdata, // r data
    output logic [1:0] s_axi_rresp, // r resp
    output logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    output logic low_irq_o, // low irq
    output logic high_irq_o, // high irq
    output logic [2:0] low_irq_priority_o, // low prio
    output logic [2:0] high_irq_priority_o, // high prio
    output logic adc_trigger_o, // adc start
    output logic low_dma_req_o, // low dma
    output logic high_dma_req_o // high dma
);
    typedef struct packed {
        logic [1:0] lo_sync;
        logic [1:0] hi_sync;
        logic lo_pin_prev;
        logic hi_pin_prev;
        logic [1:0] lo_ps_sync;
        logic lo_ps_prev;
        logic insn_div;
        logic lo_gate_prev;
        logic hi_gate_prev;
        logic [15:0] lo_ctrl;
        logic [15:0] hi_ctrl;
        logic [15:0] lo_period;
        logic [15:0] hi_period;
        logic [15:0] lo_count;
        logic [15:0] hi_count;
        logic lo_flag;
        logic hi_flag;
        logic lo_ie;
        logic hi_ie;
        logic [2:0] lo_ip;
        logic [2:0] hi_ip;
        logic adc_en;
        logic adc_trig;
        logic lo_dma;
        logic hi_dma;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tp_state_t;
    tp_state_t s_q, s_d;

    logic hi_pin_rise, insn_tick;
    logic wide, lo_run, hi_run, lo_src, hi_src, lo_gated, hi_gated;
    logic lo_raw, hi_raw, lo_ps_tick, hi_ps_tick, lo_tick, hi_tick;
    logic lo_clear, hi_clear;
    logic [1:0] lo_sel, hi_sel;

    // merge the held write bytes, mask unimplemented bits
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] mask);
        logic [15:0] r;
        r = old;
        if (s_q.w_strb[0]) r[7:0] = s_q.w_data[7:0];
        if (s_q.w_strb[1]) r[15:8] = s_q.w_data[15:8];
        return r & mask;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // clock selection
    assign hi_pin_rise = s_q.hi_sync[1] & ~s_q.hi_pin_prev;
    assign insn_tick = (s_q.insn_div == INSN_DIV_LAST);
    assign wide = s_q.lo_ctrl[WIDE_BIT];
    // wide mode: low control governs, high idle stop still applies
    assign lo_run = s_q.lo_ctrl[RUN_BIT] && !(idle_mode_i && (s_q.lo_ctrl[IDLE_STOP_BIT] ||
                    (wide && s_q.hi_ctrl[IDLE_STOP_BIT])));
    assign hi_run = (wide ? s_q.lo_ctrl[RUN_BIT] : s_q.hi_ctrl[RUN_BIT]) &&
                    !(idle_mode_i && s_q.hi_ctrl[IDLE_STOP_BIT]);
    assign lo_src = s_q.lo_ctrl[CLK_SRC_BIT];
    assign hi_src = s_q.hi_ctrl[CLK_SRC_BIT];
    assign lo_gated = s_q.lo_ctrl[GATE_BIT] && !lo_src;
    assign hi_gated = s_q.hi_ctrl[GATE_BIT] && !hi_src;
    assign lo_sel = s_q.lo_ctrl[PRESCALE_LSB+:2];
    assign hi_sel = s_q.hi_ctrl[PRESCALE_LSB+:2];
    // low timer: prescale first, synchronise after
    assign lo_raw = lo_src ? low_ext_count_input_i
                           : (insn_tick && (!lo_gated || s_q.lo_sync[1]));
    // high timer: synchronise first
    assign hi_raw = hi_src ? hi_pin_rise
                           : (insn_tick && (!hi_gated || s_q.hi_sync[1]));
    assign lo_clear = !lo_run;
    assign hi_clear = !hi_run;

    // the low divider sees no ticks on the external path
    logic lo_ps_in;
    assign lo_ps_in = lo_src ? 1'b0 : lo_raw;

    tick_prescaler u_lo_ps (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .clear_i(lo_clear),
        .tick_i(lo_ps_in),
        .sel_i(lo_sel),
        .tick_o(lo_ps_tick)
    );

    tick_prescaler u_hi_ps (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .clear_i(hi_clear),
        .tick_i(hi_raw),
        .sel_i(hi_sel),
        .tick_o(hi_ps_tick)
    );

    // low external path: pin edge divider
    logic [7:0] lo_ext_div_q;
    logic lo_ext_out;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lo_ext_div_q <= 8'h00;
        end else if (lo_clear || !lo_src) begin
            lo_ext_div_q <= 8'h00;
        end else if (low_ext_count_input_i && !s_q.lo_pin_prev) begin
            lo_ext_div_q <= lo_ext_div_q + 8'h01;
        end
    end
    always_comb begin
        case (lo_sel)
            2'h0: lo_ext_out = s_q.lo_pin_prev;
            2'h1: lo_ext_out = lo_ext_div_q[2];
            2'h2: lo_ext_out = lo_ext_div_q[5];
            default: lo_ext_out = lo_ext_div_q[7];
        endcase
    end

    assign lo_tick = lo_run && (lo_src ? (s_q.lo_ps_sync[1] && !s_q.lo_ps_prev) : lo_ps_tick);
    // wide mode: high word steps with the low
    assign hi_tick = hi_run && !wide && hi_ps_tick;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic lo_match, hi_match, wide_match, lo_gate_fall, hi_gate_fall;
        logic lo_ev, hi_ev;
        lo_match = (s_q.lo_count == s_q.lo_period);
        hi_match = (s_q.hi_count == s_q.hi_period);
        wide_match = lo_match && hi_match;
        lo_gate_fall = lo_run && lo_gated && s_q.lo_gate_prev && !s_q.lo_sync[1];
        hi_gate_fall = hi_run && !wide && hi_gated && s_q.hi_gate_prev && !s_q.hi_sync[1];
        lo_ev = 1'b0;
        hi_ev = 1'b0;
        s_d = s_q;
        s_d.lo_sync = {s_q.lo_sync[0], low_ext_count_input_i};
        s_d.hi_sync = {s_q.hi_sync[0], high_ext_count_input_i};
        // raw pin sample for the low divider edge
        s_d.lo_pin_prev = low_ext_count_input_i;
        s_d.hi_pin_prev = s_q.hi_sync[1];
        s_d.lo_ps_sync = {s_q.lo_ps_sync[0], lo_ext_out};
        s_d.lo_ps_prev = s_q.lo_ps_sync[1];
        s_d.insn_div = s_q.insn_div + 1'b1;
        s_d.lo_gate_prev = s_q.lo_sync[1];
        s_d.hi_gate_prev = s_q.hi_sync[1];
        s_d.adc_trig = 1'b0;
        s_d.lo_dma = 1'b0;
        s_d.hi_dma = 1'b0;
        // counting
        if (wide) begin
            if (lo_tick) begin
                if (wide_match) begin
                    s_d.lo_count = COUNT_RESET;
                    s_d.hi_count = COUNT_RESET;
                    hi_ev = 1'b1;
                end else begin
                    {s_d.hi_count, s_d.lo_count} = {s_q.hi_count, s_q.lo_count} + 32'h1;
                end
            end
            if (lo_gate_fall) hi_ev = 1'b1;
        end else begin
            if (lo_tick) begin
                if (lo_match) begin
                    s_d.lo_count = COUNT_RESET;
                    lo_ev = 1'b1;
                end else begin
                    s_d.lo_count = s_q.lo_count + 16'h0001;
                end
            end
            if (hi_tick) begin
                if (hi_match) begin
                    s_d.hi_count = COUNT_RESET;
                    hi_ev = 1'b1;
                end else begin
                    s_d.hi_count = s_q.hi_count + 16'h0001;
                end
            end
            if (lo_gate_fall) lo_ev = 1'b1;
            if (hi_gate_fall) hi_ev = 1'b1;
        end
        s_d.adc_trig = hi_ev && s_q.adc_en;
        s_d.lo_dma = FIRST_PAIR && lo_ev;
        s_d.hi_dma = FIRST_PAIR && hi_ev;
        // bus write: address and data in either order
        if (s_axi_awvalid && !s_q.aw_got) begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_got) begin
            s_d.w_got = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = AXI_OKAY;
            case ({s_q.aw_addr[7:2], 2'b00})
                LOW_CTRL_OFF: s_d.lo_ctrl = merge16(s_q.lo_ctrl, LOW_CTRL_MASK);
                HIGH_CTRL_OFF: s_d.hi_ctrl = merge16(s_q.hi_ctrl, HIGH_CTRL_MASK);
                LOW_PERIOD_OFF: s_d.lo_period = merge16(s_q.lo_period, 16'hffff);
                HIGH_PERIOD_OFF: s_d.hi_period = merge16(s_q.hi_period, 16'hffff);
                LOW_COUNT_OFF: s_d.lo_count = merge16(s_q.lo_count, 16'hffff);
                HIGH_COUNT_OFF: s_d.hi_count = merge16(s_q.hi_count, 16'hffff);
                IRQ_FLAG_OFF: begin
                    // write one to clear
                    if (s_q.w_strb[0] && s_q.w_data[0]) s_d.lo_flag = 1'b0;
                    if (s_q.w_strb[0] && s_q.w_data[1]) s_d.hi_flag = 1'b0;
                end
                IRQ_CFG_OFF: if (s_q.w_strb[0]) begin
                    s_d.lo_ie = s_q.w_data[0];
                    s_d.lo_ip = s_q.w_data[3:1];
                    s_d.hi_ie = s_q.w_data[4];
                    s_d.hi_ip = s_q.w_data[7:5];
                end
                MISC_OFF: if (s_q.w_strb[0]) s_d.adc_en = s_q.w_data[0];
                default: s_d.bresp = AXI_SLVERR;
            endcase
        end
        if (s_q.bvalid && s_axi_bready) s_d.bvalid = 1'b0;
        // flags: set wins over clear
        if (lo_ev) s_d.lo_flag = 1'b1;
        if (hi_ev) s_d.hi_flag = 1'b1;
        // bus read
        if (s_axi_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = AXI_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                LOW_CTRL_OFF: s_d.rdata = {16'h0000, s_q.lo_ctrl};
                HIGH_CTRL_OFF: s_d.rdata = {16'h0000, s_q.hi_ctrl};
                LOW_PERIOD_OFF: s_d.rdata = {16'h0000, s_q.lo_period};
                HIGH_PERIOD_OFF: s_d.rdata = {16'h0000, s_q.hi_period};
                LOW_COUNT_OFF: s_d.rdata = {16'h0000, s_q.lo_count};
                HIGH_COUNT_OFF: s_d.rdata = {16'h0000, s_q.hi_count};
                IRQ_FLAG_OFF: s_d.rdata = {30'h0, s_q.hi_flag, s_q.lo_flag};
                IRQ_CFG_OFF: s_d.rdata = {24'h0, s_q.hi_ip, s_q.hi_ie, s_q.lo_ip, s_q.lo_ie};
                MISC_OFF: s_d.rdata = {31'h0, s_q.adc_en};
                default: begin
                    s_d.rdata = 32'h0;
                    s_d.rresp = AXI_SLVERR;
                end
            endcase
        end
        if (s_q.rvalid && s_axi_rready) s_d.rvalid = 1'b0;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
            s_q.lo_ctrl <= CTRL_RESET;
            s_q.hi_ctrl <= CTRL_RESET;
            s_q.lo_period <= PERIOD_RESET;
            s_q.hi_period <= PERIOD_RESET;
            s_q.lo_count <= COUNT_RESET;
            s_q.hi_count <= COUNT_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign s_axi_awready = !s_q.aw_got;
    assign s_axi_wready = !s_q.w_got;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign low_irq_o = s_q.lo_flag && s_q.lo_ie && !wide;
    assign high_irq_o = s_q.hi_flag && s_q.hi_ie;
    assign low_irq_priority_o = s_q.lo_ip;
    assign high_irq_priority_o = s_q.hi_ip;
    assign adc_trigger_o = s_q.adc_trig;
    assign low_dma_req_o = s_q.lo_dma;
    assign high_dma_req_o = s_q.hi_dma;
endmodule
`default_nettype wire

//--- tb/pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module pin_model (
    input wire logic clk_i, // core clock
    output logic pin_o // count or gate pin, low between bursts
);
    initial pin_o = 1'b0;
    task automatic gate(input int len);
        @(posedge clk_i);
        pin_o <= 1'b1;
        repeat (len) @(posedge clk_i);
        pin_o <= 1'b0;
    endtask
    // four high, four low: slow enough for the synchroniser
    task automatic pulses(input int n);
        repeat (n) begin
            gate(4);
            repeat (3) @(posedge clk_i);
        end
    endtask
endmodule
`default_nettype wire

//--- tb/timer_pair_chk.sv
`timescale 1ns/100ps
`default_nettype none
module timer_pair_chk
    import timer_pair_pkg::*;
(
    input wire logic sys_clk_i, // clock
    input wire logic rst_n_i, // reset
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic [1:0] s_axi_bresp, // b resp
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic [1:0] s_axi_rresp, // r resp
    input wire logic low_dma_req_o, // low dma
    input wire logic high_dma_req_o, // high dma
    input wire logic adc_trigger_o // trigger
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bvalid dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rvalid dropped");
    a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready while busy");
    a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read not zero");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
        else $error("upper read bits set");
    a_low_dma: assert property (low_dma_req_o |=> !low_dma_req_o)
        else $error("low dma too long");
    a_high_dma: assert property (high_dma_req_o |=> !high_dma_req_o)
        else $error("high dma too long");
    a_adc_pulse: assert property (adc_trigger_o |=> !adc_trigger_o)
        else $error("trigger too long");
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
    import timer_pair_pkg::*;
();
    localparam int K_RUN = 1 << RUN_BIT;
    localparam int K_IDLE = 1 << IDLE_STOP_BIT;
    localparam int K_GATE = 1 << GATE_BIT;
    localparam int K_WIDE = 1 << WIDE_BIT;
    localparam int K_EXT = 1 << CLK_SRC_BIT;
    logic sys_clk_i, rst_n_i, idle_mode_i, low_pin, high_pin;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv, keep;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic low_irq_o, high_irq_o, adc_trigger_o, low_dma_req_o, high_dma_req_o;
    logic [2:0] low_irq_priority_o, high_irq_priority_o;
    int n_fail, n_checks, i, t, p, g;
    timer_pair #(.FIRST_PAIR(1'b1)) i_dut (
        .sys_clk_i, .rst_n_i, .idle_mode_i,
        .low_ext_count_input_i(low_pin), .high_ext_count_input_i(high_pin),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .low_irq_o, .high_irq_o, .low_irq_priority_o,
        .high_irq_priority_o, .adc_trigger_o, .low_dma_req_o, .high_dma_req_o
    );
    pin_model i_lp (.clk_i(sys_clk_i), .pin_o(low_pin));
    pin_model i_hp (.clk_i(sys_clk_i), .pin_o(high_pin));
    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        n_fail++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) fail(m);
    endtask
    task automatic chk_near(input logic [31:0] got, input int exp, input int tol, input string m);
        n_checks++;
        if ((^got) === 1'bx || int'(got) < exp - tol || int'(got) > exp + tol) fail(m);
    endtask
    function automatic int div_of(input int ps);
        return ps == 0 ? 1 : ps == 1 ? 8 : ps == 2 ? 64 : 256;
    endfunction
    function automatic logic pulse(input int s);
        return s == 0 ? low_dma_req_o : s == 1 ? high_dma_req_o : adc_trigger_o;
    endfunction
    // cycles between two event pulses
    task automatic gap(input int s, output int n);
        repeat (2) begin
            n = 0;
            do begin
                @(negedge sys_clk_i);
                n++;
            end while (pulse(s) !== 1'b1 && n < 3000);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ta, tw, tb;
        @(posedge sys_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 64; n++) begin
            @(negedge sys_clk_i);
            {ta, tw, tb, rsp} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge sys_clk_i);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 64) fail("write hang");
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        logic ta, tr;
        @(posedge sys_clk_i);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (n = 0; n < 64; n++) begin
            @(negedge sys_clk_i);
            {ta, tr, rv, rsp} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge sys_clk_i);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 64) fail("read hang");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        #500000;
        fail("watchdog expired");
        give_verdict();
    end
    initial begin
        {rst_n_i, idle_mode_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        n_fail = 0;
        n_checks = 0;
        void'($urandom(32'h02e61339));
        repeat (6) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 10; i++) begin
            rd(8'(i * 4));
            chk_eq(rv, (i == 2 || i == 3) ? 32'hffff : 32'h0, "reset value");
            chk_eq({30'h0, rsp}, {30'h0, (i == 9) ? AXI_SLVERR : AXI_OKAY}, "read resp");
        end
        wr(8'h28, 32'h1);
        chk_eq({30'h0, rsp}, {30'h0, AXI_SLVERR}, "write resp");
        for (t = 0; t < 2; t++) begin
            wr(LOW_CTRL_OFF + 8'(t * 4), 32'hffff);
            rd(LOW_CTRL_OFF + 8'(t * 4));
            chk_eq(rv, {16'h0, (t == 1) ? HIGH_CTRL_MASK : LOW_CTRL_MASK}, "ctrl bits");
            wr(LOW_CTRL_OFF + 8'(t * 4), 32'h0);
        end
        wr(IRQ_CFG_OFF, 32'ha6);
        chk_eq({26'h0, high_irq_priority_o, low_irq_priority_o}, 32'h2b, "priority");
        $display("test registers done");
        for (t = 0; t < 2; t++) begin
            for (i = 0; i < 4; i++) begin
                wr(LOW_COUNT_OFF + 8'(t * 4), 32'h0);
                wr(LOW_CTRL_OFF + 8'(t * 4), K_RUN | 32'(i << PRESCALE_LSB));
                repeat (2048) @(posedge sys_clk_i);
                wr(LOW_CTRL_OFF + 8'(t * 4), 32'h0);
                rd(LOW_COUNT_OFF + 8'(t * 4));
                chk_near(rv, 2052 / (2 * div_of(i)), 2, "prescaled count");
                keep = rv;
                repeat (20) @(posedge sys_clk_i);
                rd(LOW_COUNT_OFF + 8'(t * 4));
                chk_eq(rv, keep, "stopped count");
            end
        end
        $display("test prescale done");
        wr(IRQ_CFG_OFF, 32'h11);
        for (i = 0; i < 4; i++) begin
            p = (i == 0) ? 1 : 1 + int'($urandom % 40);
            wr(LOW_PERIOD_OFF, 32'(p));
            wr(LOW_COUNT_OFF, 32'h0);
            wr(LOW_CTRL_OFF, K_RUN);
            gap(0, g);
            chk_eq(32'(g), 32'(2 * (p + 1)), "period gap");
            wr(LOW_CTRL_OFF, 32'h0);
            rd(IRQ_FLAG_OFF);
            chk_eq({30'h0, low_irq_o, rv[0]}, 32'h3, "low flag");
            wr(IRQ_FLAG_OFF, 32'h3);
            chk_eq({31'h0, low_irq_o}, 32'h0, "flag clear");
        end
        $display("test period done");
        p = 2 + int'($urandom % 20);
        wr(MISC_OFF, 32'h1);
        wr(HIGH_CTRL_OFF, K_GATE | K_EXT | 32'h30);
        wr(LOW_PERIOD_OFF, 32'(p));
        wr(HIGH_PERIOD_OFF, 32'h0);
        wr(LOW_COUNT_OFF, 32'h0);
        wr(HIGH_COUNT_OFF, 32'h0);
        wr(LOW_CTRL_OFF, K_RUN | K_WIDE);
        gap(1, g);
        chk_eq(32'(g), 32'(2 * (p + 1)), "wide gap");
        gap(2, g);
        chk_eq(32'(g), 32'(2 * (p + 1)), "trigger gap");
        chk_eq({30'h0, low_irq_o, high_irq_o}, 32'h1, "wide irq");
        wr(LOW_CTRL_OFF, 32'h0);
        wr(LOW_PERIOD_OFF, 32'hffff);
        wr(HIGH_PERIOD_OFF, 32'h1);
        wr(LOW_COUNT_OFF, 32'hfff0);
        wr(LOW_CTRL_OFF, K_RUN | K_WIDE);
        repeat (200) @(posedge sys_clk_i);
        wr(LOW_CTRL_OFF, 32'h0);
        rd(HIGH_COUNT_OFF);
        chk_eq(rv, 32'h1, "upper word");
        rd(LOW_COUNT_OFF);
        chk_near(rv, 86, 3, "lower word");
        wr(HIGH_PERIOD_OFF, 32'hffff);
        $display("test wide done");
        for (t = 0; t < 2; t++) begin
            wr(LOW_COUNT_OFF + 8'(t * 4), 32'h0);
            wr(IRQ_FLAG_OFF, 32'h3);
            wr(LOW_CTRL_OFF + 8'(t * 4), K_RUN | K_GATE);
            if (t == 0) i_lp.gate(60);
            else i_hp.gate(60);
            repeat (10) @(posedge sys_clk_i);
            rd(LOW_COUNT_OFF + 8'(t * 4));
            chk_near(rv, 30, 2, "gated count");
            rd(IRQ_FLAG_OFF);
            chk_eq({31'h0, rv[t]}, 32'h1, "gate flag");
            for (i = 0; i < 2; i++) begin
                wr(LOW_COUNT_OFF + 8'(t * 4), 32'h0);
                wr(LOW_CTRL_OFF + 8'(t * 4), K_RUN | K_GATE | K_EXT | 32'(i << PRESCALE_LSB));
                if (t == 0) i_lp.pulses(24);
                else i_hp.pulses(24);
                repeat (10) @(posedge sys_clk_i);
                rd(LOW_COUNT_OFF + 8'(t * 4));
                chk_near(rv, (i == 1) ? 3 : 24, i, "pin count");
            end
            wr(LOW_CTRL_OFF + 8'(t * 4), 32'h0);
        end
        $display("test pins done");
        idle_mode_i <= 1'b1;
        for (i = 0; i < 3; i++) begin
            wr(LOW_COUNT_OFF, 32'h0);
            wr(HIGH_CTRL_OFF, (i == 1) ? K_IDLE : 32'h0);
            wr(LOW_CTRL_OFF, K_RUN | ((i == 0) ? K_IDLE : (i == 1) ? K_WIDE : 32'h0));
            repeat (100) @(posedge sys_clk_i);
            wr(LOW_CTRL_OFF, 32'h0);
            rd(LOW_COUNT_OFF);
            chk_near(rv, (i == 2) ? 52 : 0, (i == 2) ? 2 : 0, "idle count");
        end
        idle_mode_i <= 1'b0;
        $display("test idle done");
        give_verdict();
    end
endmodule
bind timer_pair timer_pair_chk i_chk (
    .sys_clk_i, .rst_n_i, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .low_dma_req_o, .high_dma_req_o, .adc_trigger_o
);
`default_nettype wire
